// ==== ccir_pkg.sv ====
package ccir_pkg;

  // register word addresses (byte offsets on the bus)
  localparam logic [7:0] OFS_OPCOND = 8'h00;
  localparam logic [7:0] OFS_IDENT_W0 = 8'h10;
  localparam logic [7:0] OFS_IDENT_W1 = 8'h14;
  localparam logic [7:0] OFS_IDENT_W2 = 8'h18;
  localparam logic [7:0] OFS_IDENT_W3 = 8'h1C;
  localparam logic [7:0] OFS_SPECDATA_W0 = 8'h20;
  localparam logic [7:0] OFS_SPECDATA_W3 = 8'h2C;
  localparam logic [7:0] OFS_RADDR = 8'h30;
  localparam logic [7:0] OFS_DRV_STAGE = 8'h34;
  localparam logic [7:0] OFS_FEAT_W0 = 8'h38;
  localparam logic [7:0] OFS_FEAT_W1 = 8'h3C;
  localparam logic [7:0] OFS_STAT_W0 = 8'h40;
  localparam logic [7:0] OFS_STAT_W15 = 8'h7C;
  localparam logic [7:0] OFS_CTRL = 8'h80;

  // operating-condition field positions
  localparam int OPC_WIN_LO = 15;
  localparam int OPC_WIN_HI = 23;
  localparam int OPC_CAP_BIT = 30;
  localparam int OPC_BUSY_BIT = 31;
  localparam logic [8:0] OPC_WINDOW_RST = 9'h1FF;

  // identification field positions
  localparam int IDN_MAKER_LSB = 120;
  localparam int IDN_OEM_LSB = 104;
  localparam int IDN_NAME_LSB = 64;
  localparam int IDN_REV_LSB = 56;
  localparam int IDN_SERIAL_LSB = 24;
  localparam int IDN_DATE_LSB = 8;
  localparam int IDN_CRC_LSB = 1;

  // power-up routine length
  localparam int POWERUP_TIME_US = 10;
  localparam int CLK_MHZ = 100;
  localparam int POWERUP_CYCLES = POWERUP_TIME_US * CLK_MHZ;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] RADDR_RST = 16'h0000;

  typedef struct packed {
    logic [7:0] maker;
    logic [15:0] oemCode;
    logic [39:0] productName;
    logic [7:0] productRevision;
    logic [31:0] serialNumber;
    logic [11:0] manufacturingDate;
  } ccir_ident_s;

  typedef enum logic [1:0] {ST_IDLE, ST_WRESP, ST_RDATA} ccir_bus_e;

endpackage

// ==== ccir_regs.sv ====
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
// How it works
// - 32-bit operating word; bits 15..23 give the 2.7-3.6 V window.
// - bits 0-14 and 24-29 read zero; bit 7 kept for low voltage.
// - bit 31 low until the power-up counter finishes, then high.
// - capacity bit shows only while bit 31 is high.
// - 128-bit identification word, unique per device via parameters.
// - maker, oem, name, revision, serial packed at their fixed slices.
// - bits 23:20 zero, date 19:8, crc7 7:1, bit 0 one.
// - csd 128, relative address 16, special 64, status 512 bits held.
// - no driver-stage register; its would-be address errors out.
module ccir_regs import ccir_pkg::*; #(
  parameter ccir_ident_s IDENT = '{8'h5A, 16'h4242, 40'h4142434445, 8'h10,
    32'h00000001, 12'h001}, // arbitrary identity values
  parameter logic HIGH_CAPACITY = 1'b1,
  parameter int POWERUP_LEN = POWERUP_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite write address and data
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // card state
  output logic powerUpDone
);

  // crc7 over the upper 120 identification bits, polynomial x^7+x^3+1
  function automatic logic [6:0] crc7(input logic [119:0] d);
    logic [6:0] c;
    logic fb;
    c = '0;
    for (int i = 119; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ 7'h09;
      end
    end
    return c;
  endfunction

  // place every identification field at its fixed slice
  // the reserved nibble stays zero because the word starts cleared
  function automatic logic [127:0] identLayout(input ccir_ident_s id);
    logic [127:0] w;
    w = '0;
    w[IDN_MAKER_LSB +: 8] = id.maker;
    w[IDN_OEM_LSB +: 16] = id.oemCode;
    w[IDN_NAME_LSB +: 40] = id.productName;
    w[IDN_REV_LSB +: 8] = id.productRevision;
    w[IDN_SERIAL_LSB +: 32] = id.serialNumber;
    w[IDN_DATE_LSB +: 12] = id.manufacturingDate;
    // checksum covers everything above it, bit 0 is always one
    w[IDN_CRC_LSB +: 7] = crc7(w[127:8]);
    w[0] = 1'b1;
    return w;
  endfunction

  // identification word; a constant, so no write can ever reach it
  // each device gets its own value through the IDENT parameter
  localparam logic [127:0] IDENT_WORD = identLayout(IDENT);

  // register regions seen by the bus
  typedef enum {
    SEL_OPCOND,
    SEL_IDENT,
    SEL_SPEC,
    SEL_RADDR,
    SEL_FEAT,
    SEL_STATUS,
    SEL_CTRL,
    SEL_NONE
  } ccir_sel_e;

  // all state of the block
  typedef struct packed {
    ccir_bus_e wst;
    ccir_bus_e rst;
    logic awHave;
    logic wHave;
    logic [7:0] wAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awRdy;
    logic wRdy;
    logic bValid;
    logic [1:0] bresp;
    logic arRdy;
    logic rValid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] upCount;
    logic busyDone;
    logic [8:0] window;
    logic [127:0] specData;
    logic [15:0] relAddr;
    logic [63:0] special;
    logic [511:0] status;
  } ccir_state_s;

  ccir_state_s q;
  ccir_state_s next_q;

  // address decode shared by the write and read paths
  // the driver-stage address falls through to no region on purpose
  function automatic ccir_sel_e regionOf(input logic [7:0] a);
    ccir_sel_e s;
    if (a == OFS_OPCOND) begin
      s = SEL_OPCOND;
    end else if (a >= OFS_IDENT_W0 && a <= OFS_IDENT_W3) begin
      s = SEL_IDENT;
    end else if (a >= OFS_SPECDATA_W0 && a <= OFS_SPECDATA_W3) begin
      s = SEL_SPEC;
    end else if (a == OFS_RADDR) begin
      s = SEL_RADDR;
    end else if (a == OFS_FEAT_W0 || a == OFS_FEAT_W1) begin
      s = SEL_FEAT;
    end else if (a >= OFS_STAT_W0 && a <= OFS_STAT_W15) begin
      s = SEL_STATUS;
    end else if (a == OFS_CTRL) begin
      s = SEL_CTRL;
    end else begin
      s = SEL_NONE;
    end
    return s;
  endfunction

  // operating word, assembled from state
  // reserved bits, bit 7 included, are never set
  function automatic logic [31:0] opCondWord(input logic done, input logic [8:0] win);
    logic [31:0] v;
    v = '0;
    v[OPC_WIN_HI:OPC_WIN_LO] = win;
    // capacity only means something once power-up is done
    v[OPC_CAP_BIT] = done & HIGH_CAPACITY;
    v[OPC_BUSY_BIT] = done;
    return v;
  endfunction

  // merge bytes under strobe
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
    input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // read data for one region; idx is the word index of the address
  function automatic logic [31:0] readWord(input ccir_state_s s, input ccir_sel_e sel,
    input logic [4:0] idx);
    logic [31:0] v;
    v = '0;
    case (sel)
      SEL_OPCOND: begin
        v = opCondWord(s.busyDone, s.window);
      end
      SEL_IDENT: begin
        v = IDENT_WORD[idx[1:0]*32 +: 32];
      end
      SEL_SPEC: begin
        v = s.specData[idx[1:0]*32 +: 32];
      end
      SEL_RADDR: begin
        v = {16'h0000, s.relAddr};
      end
      SEL_FEAT: begin
        v = s.special[idx[0]*32 +: 32];
      end
      SEL_STATUS: begin
        v = s.status[idx[3:0]*32 +: 32];
      end
      SEL_CTRL: begin
        v = {23'h0, s.window};
      end
      default: begin
        v = '0;
      end
    endcase
    return v;
  endfunction

  // next state
  always_comb begin
    logic [4:0] wIdx;
    logic [4:0] rIdx;
    ccir_sel_e wSel;
    ccir_sel_e rSel;
    next_q = q;
    wIdx = q.wAddr[6:2];
    rIdx = araddr[6:2];
    wSel = regionOf(q.wAddr);
    rSel = regionOf(araddr);

    // power-up routine counter; the flag never drops once set
    if (!q.busyDone) begin
      if (q.upCount == 16'(POWERUP_LEN - 1)) begin
        next_q.busyDone = 1'b1;
      end else begin
        next_q.upCount = q.upCount + 16'h0001;
      end
    end

    // write channel: address and data taken in either order
    case (q.wst)
      ST_IDLE: begin
        if (awvalid && q.awRdy) begin
          next_q.awHave = 1'b1;
          next_q.wAddr = awaddr;
        end
        if (wvalid && q.wRdy) begin
          next_q.wHave = 1'b1;
          next_q.wData = wdata;
          next_q.wStrb = wstrb;
        end
        // both halves held: commit one cycle later and answer
        if (q.awHave && q.wHave) begin
          next_q.awHave = 1'b0;
          next_q.wHave = 1'b0;
          next_q.wst = ST_WRESP;
          next_q.bresp = RESP_OKAY;
          case (wSel)
            SEL_SPEC: begin
              next_q.specData[wIdx[1:0]*32 +: 32] = merge(q.specData[wIdx[1:0]*32 +: 32],
                q.wData, q.wStrb);
            end
            SEL_RADDR: begin
              next_q.relAddr = 16'(merge({16'h0000, q.relAddr}, q.wData, q.wStrb));
            end
            SEL_FEAT: begin
              next_q.special[wIdx[0]*32 +: 32] = merge(q.special[wIdx[0]*32 +: 32],
                q.wData, q.wStrb);
            end
            SEL_STATUS: begin
              next_q.status[wIdx[3:0]*32 +: 32] = merge(q.status[wIdx[3:0]*32 +: 32],
                q.wData, q.wStrb);
            end
            SEL_CTRL: begin
              next_q.window = 9'(merge({23'h0, q.window}, q.wData, q.wStrb));
            end
            default: begin
              // read-only words and the missing driver stage refuse writes
              next_q.bresp = RESP_SLVERR;
            end
          endcase
        end
      end
      default: begin
        // response stands until the master takes it
        if (bready) begin
          next_q.wst = ST_IDLE;
        end
      end
    endcase

    // read channel: data one cycle after the address is taken
    case (q.rst)
      ST_IDLE: begin
        if (arvalid) begin
          next_q.rst = ST_RDATA;
          next_q.rdata = readWord(q, rSel, rIdx);
          if (rSel == SEL_NONE) begin
            next_q.rresp = RESP_SLVERR;
          end else begin
            next_q.rresp = RESP_OKAY;
          end
        end
      end
      default: begin
        // data stands until the master takes it
        if (rready) begin
          next_q.rst = ST_IDLE;
        end
      end
    endcase

    // handshake pins registered from the next state, so each is a flip-flop
    next_q.awRdy = next_q.wst == ST_IDLE && !next_q.awHave;
    next_q.wRdy = next_q.wst == ST_IDLE && !next_q.wHave;
    next_q.bValid = next_q.wst == ST_WRESP;
    next_q.arRdy = next_q.rst == ST_IDLE;
    next_q.rValid = next_q.rst == ST_RDATA;
  end

  // state register; ready pins come out of reset high, valid pins low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{wst: ST_IDLE, rst: ST_IDLE, window: OPC_WINDOW_RST, relAddr: RADDR_RST,
        awRdy: 1'b1, wRdy: 1'b1, arRdy: 1'b1, default: '0};
    end else begin
      q <= next_q;
    end
  end

  // outputs straight from flip-flops
  assign awready = q.awRdy;
  assign wready = q.wRdy;
  assign bvalid = q.bValid;
  assign bresp = q.bresp;
  assign arready = q.arRdy;
  assign rvalid = q.rValid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign powerUpDone = q.busyDone;

endmodule

// ==== ccir_regs_asserts.sv ====
`timescale 1ns/1ns
module ccir_regs_asserts import ccir_pkg::*; (
  // clock and reset
  input wire logic clk, rst_n,
  // bus side
  input wire logic [7:0] awaddr, araddr,
  input wire logic awvalid, awready, bvalid, arvalid, arready, rvalid,
  input wire logic [1:0] bresp, rresp,
  input wire logic [31:0] rdata,
  // card state
  input wire logic powerUpDone
);
  logic [7:0] ra, wa;
  // address of the transfer in flight
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ra <= 8'h00;
      wa <= 8'h00;
    end else begin
      if (arvalid && arready) ra <= araddr;
      if (awvalid && awready) wa <= awaddr;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence opRd; rvalid && ra == OFS_OPCOND; endsequence
  sequence idRd; rvalid && ra == OFS_IDENT_W0; endsequence
  sequence roWr; bvalid && (wa == OFS_OPCOND || wa[7:4] == 4'h1); endsequence
  sequence rwRd;
    rvalid && ra inside {[OFS_SPECDATA_W0:OFS_RADDR], [OFS_FEAT_W0:OFS_STAT_W15]};
  endsequence
  resv_zero_a: assert property (opRd |-> {rdata[29:24], rdata[14:0]} == 21'h0)
    else $error("reserved operating bits set");
  busy_gate_a: assert property (opRd ##0 rdata[31] |-> powerUpDone)
    else $error("ready bit before power-up end");
  busy_keep_a: assert property (powerUpDone |=> powerUpDone)
    else $error("power-up flag dropped");
  cap_valid_a: assert property (opRd ##0 rdata[30] |-> rdata[31])
    else $error("capacity bit without ready bit");
  id_tail_a: assert property (idRd |-> rdata[0] && rdata[23:20] == 4'h0)
    else $error("identification tail wrong");
  ro_write_a: assert property (roWr |-> bresp == RESP_SLVERR)
    else $error("read-only word accepted a write");
  rw_okay_a: assert property (rwRd |-> rresp == RESP_OKAY)
    else $error("held register refused a read");
  drv_none_a: assert property (rvalid && ra == OFS_DRV_STAGE |-> rresp == RESP_SLVERR
    && rdata == 32'h0)
    else $error("driver-stage word answered");
endmodule
bind ccir_regs ccir_regs_asserts chk (.clk, .rst_n, .awaddr, .araddr, .awvalid, .awready,
  .bvalid, .arvalid, .arready, .rvalid, .bresp, .rresp, .rdata, .powerUpDone);

// ==== ccir_host.sv ====
`timescale 1ns/1ns
module ccir_host (
  // clock and stuck flag
  input wire logic clk,
  output logic timedOut,
  // requests
  output logic [7:0] awaddr, araddr,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic awvalid, wvalid, bready, arvalid, rready,
  // answers
  input wire logic awready, wready, bvalid, arready, rvalid
);
  // idle bus, full-word strobes
  initial {timedOut, awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid, rready} =
    {49'h0, 4'hF, 5'h0};
  // one transfer; payload held until taken, ready held until answered
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic [3:0] t;
    @(posedge clk);
    if (w) {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    else {araddr, arvalid, rready} <= {a, 2'b11};
    for (int n = 0; n < 100; n++) begin
      @(negedge clk);
      t = {awvalid & awready, wvalid & wready, arvalid & arready,
        bvalid & bready | rvalid & rready};
      @(posedge clk);
      awvalid <= awvalid & ~t[3];
      wvalid <= wvalid & ~t[2];
      arvalid <= arvalid & ~t[1];
      if (t[0]) begin
        {bready, rready} <= 2'b00;
        return;
      end
    end
    timedOut <= 1'b1;
  endtask
endmodule

// ==== card_condition_and_id_regs_test.sv ====
`timescale 1ns/1ns
module card_condition_and_id_regs_test;
  import ccir_pkg::*;
  localparam int PL = 40;
  localparam ccir_ident_s ID = '{8'h3C, 16'h1234, 40'h0102030405, 8'h21, 32'h00ABCDEF,
    12'h0A5}; // arbitrary identity values
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic powerUpDone, timedOut;
  logic [119:0] m;
  logic [127:0] idWord;
  logic [34:0] q[$];
  logic [34:0] e;
  logic [33:0] g;
  logic [7:0] rw[7] = '{OFS_SPECDATA_W0, OFS_SPECDATA_W3, OFS_RADDR, OFS_FEAT_W0, OFS_FEAT_W1,
    OFS_STAT_W0, OFS_STAT_W15};
  int num_errors = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  ccir_regs #(.IDENT(ID), .POWERUP_LEN(PL)) dut (.clk, .rst_n, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .powerUpDone);
  ccir_host host (.clk, .timedOut, .awaddr, .araddr, .wdata, .wstrb, .awvalid, .wvalid,
    .bready, .arvalid, .rready, .awready, .wready, .bvalid, .arready, .rvalid);
  // compare each answer with the oldest note
  always @(negedge clk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      e = q.pop_front();
      g = e[34] ? {bresp, 32'h0} : {rresp, rdata};
      n_tests++;
      if (g !== e[33:0]) begin
        $display("CHECK FAILED %s exp %h got %h", e[34] ? "bresp" : "rdata", e[33:0], g);
        num_errors++;
      end
    end
  end
  function automatic logic [6:0] crc7(input logic [119:0] v);
    logic [6:0] c = 7'h00;
    for (int i = 119; i >= 0; i--) c = {c[5:0], 1'b0} ^ ((v[i] ^ c[6]) ? 7'h09 : 7'h00);
    return c;
  endfunction
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] r);
    q.push_back({1'b0, r, x});
    host.xfer(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] x, input logic [1:0] r);
    q.push_back({1'b1, r, 32'h0});
    host.xfer(1'b1, a, x);
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // a stuck handshake ends the run
  always @(posedge timedOut) begin
    num_errors++;
    end_of_test;
  end
  // main sequence
  initial begin
    void'($urandom(32'hEE6D));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_OPCOND, 32'h00FF8000, RESP_OKAY);
    rd(OFS_CTRL, 32'h000001FF, RESP_OKAY);
    rd(OFS_RADDR, 32'h0, RESP_OKAY);
    @(negedge clk);
    n_tests++;
    if (powerUpDone !== 1'b0) begin
      $display("CHECK FAILED powerUpDone exp 0 got %b", powerUpDone);
      num_errors++;
    end
    repeat (PL + 10) @(posedge clk);
    @(negedge clk);
    n_tests++;
    if (powerUpDone !== 1'b1) begin
      $display("CHECK FAILED powerUpDone exp 1 got %b", powerUpDone);
      num_errors++;
    end
    d = $urandom & 32'h1FF;
    wr(OFS_CTRL, d, RESP_OKAY);
    rd(OFS_OPCOND, {2'b11, 6'h0, d[8:0], 15'h0}, RESP_OKAY);
    wr(OFS_OPCOND, 32'hFFFFFFFF, RESP_SLVERR);
    m = {ID[115:12], 4'h0, ID[11:0]};
    idWord = {m, crc7(m), 1'b1};
    for (int i = 0; i < 4; i++) begin
      wr(OFS_IDENT_W0 + 8'(4 * i), ~idWord[32 * i +: 32], RESP_SLVERR);
      rd(OFS_IDENT_W0 + 8'(4 * i), idWord[32 * i +: 32], RESP_OKAY);
    end
    rd(OFS_DRV_STAGE, 32'h0, RESP_SLVERR);
    wr(OFS_DRV_STAGE, 32'hF, RESP_SLVERR);
    foreach (rw[i]) begin
      d = $urandom & (rw[i] == OFS_RADDR ? 32'hFFFF : 32'hFFFFFFFF);
      wr(rw[i], d, RESP_OKAY);
      rd(rw[i], d, RESP_OKAY);
    end
    end_of_test;
  end
endmodule
